/* File: pss_delay.sv */
// delay line: fixed pipeline with a shorter bypass tap
`timescale 1ns/1ns
module pss_delay #(
    parameter int DEPTH     = 8,
    parameter int DEPTH_BYP = 2
) (
    input  wire logic clk,
    input  wire logic arst_n,
    pss_lat_if.dly    lat
);
    logic [5:0] stage [DEPTH];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                stage[i] <= 6'h00;
        end
        else
        begin
            stage[0] <= {lat.in_valid, lat.in_data};
            for (int i = 1; i < DEPTH; i++)
                stage[i] <= stage[i-1];
        end
    end

    assign lat.out_valid = lat.bypass ? stage[DEPTH_BYP-1][5]
                                      : stage[DEPTH-1][5];
    assign lat.out_data  = lat.bypass ? stage[DEPTH_BYP-1][4:0]
                                      : stage[DEPTH-1][4:0];
endmodule : pss_delay

/* File: pss_host_model.sv */
// partner: host that sequences supplies and the hard reset pin
`timescale 1ns/1ns
module pss_host_model
    import pss_pkg::*;
(
    input  wire logic clk,
    input  wire logic pwr_req,
    input  wire logic rst_req,
    output logic      power_good,
    output logic      hard_reset_n,
    output logic      mdc
);
    // ********************************
    // supply and reset pin sequencing
    // ********************************
    // nominal management clock of 2.5 MHz, well under the 20 MHz ceiling
    localparam int MDC_HALF_CYC = 20;
    localparam int PWR_WAIT_CYC = HOST_MGMT_PWR_MS * 1000 * CLK_MHZ;
    localparam int RST_WAIT_CYC = HOST_MGMT_RST_MS * 1000 * CLK_MHZ;
    int cnt = 0;
    int mgmt_wait = PWR_WAIT_CYC;
    int mdc_cnt = 0;
    initial power_good = 1'b0;
    initial hard_reset_n = 1'b1;
    initial mdc = 1'b0;
    always @(negedge clk)
    begin
        power_good <= pwr_req;
        // reset low is stretched to its minimum width
        cnt <= rst_req ? HOST_RST_MIN_US * CLK_MHZ
                       : (cnt > 0 ? cnt - 1 : 0);
        hard_reset_n <= !(rst_req || cnt > 1);
    end
    // management stays silent until the power-up or reset wait has run out
    always @(negedge clk)
    begin
        if (!power_good)
            mgmt_wait <= PWR_WAIT_CYC;
        else if (!hard_reset_n && mgmt_wait < RST_WAIT_CYC)
            mgmt_wait <= RST_WAIT_CYC;
        else if (mgmt_wait > 0)
            mgmt_wait <= mgmt_wait - 1;
        if (mgmt_wait > 0 || mdc_cnt == MDC_HALF_CYC - 1)
            mdc_cnt <= 0;
        else
            mdc_cnt <= mdc_cnt + 1;
        if (mgmt_wait > 0)
            mdc <= 1'b0;
        else if (mdc_cnt == MDC_HALF_CYC - 1)
            mdc <= !mdc;
    end
endmodule : pss_host_model

/* File: pss_lat_if.sv */
// interface: one latency path between the sequencer and its delay line
`timescale 1ns/1ns
interface pss_lat_if;
    logic       in_valid;
    logic [4:0] in_data;
    logic       bypass;
    logic       out_valid;
    logic [4:0] out_data;
    modport src (output in_valid, output in_data, output bypass,
                 input out_valid, input out_data);
    modport dly (input in_valid, input in_data, input bypass,
                 output out_valid, output out_data);
endinterface : pss_lat_if

/* File: pss_pkg.sv */
// package: start-up and reset timing constants for the phy sequencer
package pss_pkg;
    localparam int CLK_MHZ            = 100;
    // times in their own units, as printed
    localparam int STRAP_PWR_MS       = 60;
    localparam int STRAP_RST_US       = 2;
    localparam int FUNC_PWR_NS        = 110;
    localparam int FUNC_RST_NS        = 1500;
    localparam int IDLE_PWR_MS        = 60;
    localparam int IDLE_RST_US        = 1500;
    localparam int RX_LAT_NS          = 8000;
    localparam int RX_LAT_BYP_NS      = 400;
    localparam int TX_LAT_NS          = 800;
    localparam int TX_LAT_BYP_NS      = 600;
    localparam int RX_SHIFT_PS        = 2650;
    localparam int HOST_RST_MIN_US    = 5;
    localparam int HOST_MGMT_RST_MS   = 1;
    localparam int HOST_MGMT_PWR_MS   = 65;
    localparam int MDC_MAX_MHZ        = 20;
    // limit times round down to cycles
    localparam int STRAP_PWR_CYC      = STRAP_PWR_MS * 1000 * CLK_MHZ;
    localparam int STRAP_RST_CYC      = STRAP_RST_US * CLK_MHZ;
    localparam int FUNC_PWR_CYC       = FUNC_PWR_NS * CLK_MHZ / 1000;
    localparam int FUNC_RST_CYC       = FUNC_RST_NS * CLK_MHZ / 1000;
    localparam int IDLE_PWR_CYC       = IDLE_PWR_MS * 1000 * CLK_MHZ;
    localparam int IDLE_RST_CYC       = IDLE_RST_US * CLK_MHZ;
    localparam int RX_LAT_CYC         = RX_LAT_NS * CLK_MHZ / 1000;
    localparam int RX_LAT_BYP_CYC     = RX_LAT_BYP_NS * CLK_MHZ / 1000;
    localparam int TX_LAT_CYC         = TX_LAT_NS * CLK_MHZ / 1000;
    localparam int TX_LAT_BYP_CYC     = TX_LAT_BYP_NS * CLK_MHZ / 1000;
    // own sequencing choices, well inside the limits
    localparam int STRAP_SAMPLE_CYC   = 16;
    localparam int FUNC_DELAY_CYC     = 4;
    localparam int IDLE_DELAY_CYC     = 64;
    localparam int RX_PIPE_CYC        = 8;
    localparam int RX_PIPE_BYP_CYC    = 2;
    localparam int TX_PIPE_CYC        = 8;
    localparam int TX_PIPE_BYP_CYC    = 2;
    localparam int CNT_W              = 32;
    typedef enum logic [2:0] {
        PSS_OFF    = 3'b000,
        PSS_SAMPLE = 3'b001,
        PSS_HANDOV = 3'b011,
        PSS_WARM   = 3'b010,
        PSS_RUN    = 3'b110
    } pss_state_type;
endpackage : pss_pkg

/* File: pss_seq.sv */
// top: start-up sequencer, strap capture and rgmii/line latency paths
`timescale 1ns/1ns
//
// Contract
// - straps are captured within 60 ms after power-up.
// - straps are captured within 2 us after hard reset release.
// - strap pins go functional within 110 ns (power) or 1.5 us (reset).
// - as master, idle stream starts within 60 ms of power-up.
// - as master, idle stream starts within 1500 us of reset release.
// - receive control asserts within 8 us, or 400 ns with fec bypassed.
// - transmit delimiter reaches line within 0.8 us, or 600 ns bypassed.
// - receive path defaults to shift mode, about 2.650 ns data delay.
module pss_seq
    import pss_pkg::*;
#(
    parameter int STRAP_W = 4
) (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               power_good,
    input  wire logic               hard_reset_n,
    input  wire logic [STRAP_W-1:0] strap_in,
    input  wire logic               strap_master,
    input  wire logic               fec_bypass,
    input  wire logic               rx_align_req,
    input  wire logic               line_ssd,
    input  wire logic [3:0]         line_rxd,
    input  wire logic               tx_ctrl,
    input  wire logic [3:0]         tx_d,
    output logic [STRAP_W-1:0]      strap_value,
    output logic                    strap_done,
    output logic                    strap_pin_oe_n,
    output logic                    pin_functional,
    output logic                    line_idle,
    output logic                    rx_ctrl,
    output logic [3:0]              rx_d,
    output logic                    rx_shift_mode,
    output logic                    line_tx_ssd,
    output logic [3:0]              line_txd
);
    // ****************************************************
    // start-up sequence
    // ****************************************************
    pss_state_type state;
    pss_state_type next_state;
    logic [CNT_W-1:0] cnt;
    logic             from_reset;
    logic             up;
    logic             is_master;

    assign up = power_good && hard_reset_n;

    always_comb
    begin
        next_state = state;
        unique case (state)
            PSS_OFF:    if (up) next_state = PSS_SAMPLE;
            PSS_SAMPLE: if (cnt == CNT_W'(STRAP_SAMPLE_CYC - 1))
                            next_state = PSS_HANDOV;
            PSS_HANDOV: if (cnt == CNT_W'(FUNC_DELAY_CYC - 1))
                            next_state = PSS_WARM;
            PSS_WARM:   if (cnt == CNT_W'(IDLE_DELAY_CYC - 1))
                            next_state = PSS_RUN;
            PSS_RUN:    next_state = PSS_RUN;
            default:    next_state = PSS_OFF;
        endcase
        if (!up)
            next_state = PSS_OFF;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= PSS_OFF;
        else
            state <= next_state;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt <= '0;
        else if (next_state != state)
            cnt <= '0;
        else
            cnt <= cnt + CNT_W'(1);
    end

    // remembers whether the last start came from a reset pin release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            from_reset <= 1'b0;
        else if (!power_good)
            from_reset <= 1'b0;
        else if (!hard_reset_n)
            from_reset <= 1'b1;
    end

    // ****************************************************
    // strap capture and pin handover
    // ****************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_value <= '0;
            is_master   <= 1'b0;
        end
        else if (state == PSS_SAMPLE && next_state == PSS_HANDOV)
        begin
            strap_value <= strap_in;
            is_master   <= strap_master;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_done     <= 1'b0;
            pin_functional <= 1'b0;
            line_idle      <= 1'b0;
        end
        else
        begin
            strap_done     <= next_state inside {PSS_HANDOV, PSS_WARM,
                                                 PSS_RUN};
            pin_functional <= next_state inside {PSS_WARM, PSS_RUN};
            line_idle      <= next_state == PSS_RUN && is_master;
        end
    end

    // straps are inputs until handover, then the device drives them
    assign strap_pin_oe_n = !pin_functional;

    // ****************************************************
    // receive and transmit latency paths
    // ****************************************************
    pss_lat_if rx_lat ();
    pss_lat_if tx_lat ();

    assign rx_lat.in_valid = line_ssd && pin_functional;
    assign rx_lat.in_data  = {1'b0, line_rxd};
    assign rx_lat.bypass   = fec_bypass;
    assign tx_lat.in_valid = tx_ctrl && pin_functional;
    assign tx_lat.in_data  = {1'b0, tx_d};
    assign tx_lat.bypass   = fec_bypass;

    pss_delay #(.DEPTH(RX_PIPE_CYC), .DEPTH_BYP(RX_PIPE_BYP_CYC)) u_rx (
        .clk    (clk),
        .arst_n (arst_n),
        .lat    (rx_lat.dly)
    );

    pss_delay #(.DEPTH(TX_PIPE_CYC), .DEPTH_BYP(TX_PIPE_BYP_CYC)) u_tx (
        .clk    (clk),
        .arst_n (arst_n),
        .lat    (tx_lat.dly)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_ctrl     <= 1'b0;
            rx_d        <= 4'h0;
            line_tx_ssd <= 1'b0;
            line_txd    <= 4'h0;
        end
        else
        begin
            rx_ctrl     <= rx_lat.out_valid;
            rx_d        <= rx_lat.out_data[3:0];
            line_tx_ssd <= tx_lat.out_valid;
            line_txd    <= tx_lat.out_data[3:0];
        end
    end

    // shift mode is the default; align only on request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rx_shift_mode <= 1'b1;
        else
            rx_shift_mode <= !rx_align_req;
    end

    // ****************************************************
    // checks
    // ****************************************************
    chk_strap_pwr_done: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(up) && !from_reset |-> ##[1:30] strap_done)
        else $error("straps not captured after power-up");
    chk_strap_rst_done: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(hard_reset_n) && power_good |-> ##[1:30] strap_done)
        else $error("straps not captured after reset");
    chk_func_handover: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(strap_done) && up |-> ##[1:10] pin_functional)
        else $error("strap pins late to functional mode");
    chk_pins_after_strap: assert property (@(posedge clk)
        disable iff (!arst_n) $rose(pin_functional) |->
        $past(strap_done, FUNC_DELAY_CYC))
        else $error("pins functional before strap capture");
    chk_idle_pwr: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(up) && !from_reset && strap_master |->
        ##[1:120] (line_idle || !up))
        else $error("idle stream late after power-up");
    chk_idle_rst: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(hard_reset_n) && power_good && strap_master |->
        ##[1:120] (line_idle || !up))
        else $error("idle stream late after reset");
    chk_rx_latency: assert property (@(posedge clk) disable iff (!arst_n)
        rx_lat.in_valid && !fec_bypass |-> ##[1:800] rx_ctrl)
        else $error("receive control late");
    chk_rx_byp_lat: assert property (@(posedge clk) disable iff (!arst_n)
        rx_lat.in_valid && fec_bypass ##1 fec_bypass[*2] |->
        ##[0:37] rx_ctrl)
        else $error("receive control late in bypass");
    chk_tx_latency: assert property (@(posedge clk) disable iff (!arst_n)
        tx_lat.in_valid && !fec_bypass |-> ##[1:80] line_tx_ssd)
        else $error("transmit delimiter late");
    chk_tx_byp_lat: assert property (@(posedge clk) disable iff (!arst_n)
        tx_lat.in_valid && fec_bypass ##1 fec_bypass[*2] |->
        ##[0:57] line_tx_ssd)
        else $error("transmit delimiter late in bypass");
    chk_rx_shift_dflt: assert property (@(posedge clk) disable iff (!arst_n)
        !rx_align_req |=> rx_shift_mode)
        else $error("receive shift mode not default");
endmodule : pss_seq

/* File: pss_seq_tb.sv */
// testbench: start-up, reset and latency checks of the sequencer
`timescale 1ns/1ns
module pss_seq_tb
    import pss_pkg::*;
;
    // ********************************
    // signals and instances
    // ********************************
    logic       clk, arst_n, pwr_req, rst_req, power_good, hard_reset_n;
    logic [3:0] strap_in, line_rxd, tx_d, strap_value, rx_d, line_txd;
    logic       strap_master, fec_bypass, rx_align_req, line_ssd, tx_ctrl;
    logic       strap_done, strap_pin_oe_n, pin_functional, line_idle;
    logic       rx_ctrl, rx_shift_mode, line_tx_ssd, mdc;
    int         errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    pss_host_model host_u (.clk, .pwr_req, .rst_req, .power_good,
                           .hard_reset_n, .mdc);
    pss_seq #(.STRAP_W(4)) dut_u (.clk, .arst_n, .power_good,
        .hard_reset_n, .strap_in, .strap_master, .fec_bypass,
        .rx_align_req, .line_ssd, .line_rxd, .tx_ctrl, .tx_d,
        .strap_value, .strap_done, .strap_pin_oe_n, .pin_functional,
        .line_idle, .rx_ctrl, .rx_d, .rx_shift_mode, .line_tx_ssd,
        .line_txd);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********************************
    // shared tasks
    // ********************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    // ********************************
    // scenarios
    // ********************************
    task automatic seq_check(input int lsd, lpf, lid, input logic m,
                             input logic [3:0] s);
        int a = 0;
        int b = 0;
        int c = 0;
        logic oe_exp;
        for (int k = 1; k < 400; k++)
        begin
            @(negedge clk);
            if (strap_done === 1'b1 && a == 0) a = k;
            if (pin_functional === 1'b1 && b == 0) b = k;
            if (line_idle === 1'b1 && c == 0) c = k;
            // pins stay inputs until the handover delay after capture
            oe_exp = !(a > 0 && k - a >= FUNC_DELAY_CYC);
            chk("strap_pin_oe_n", oe_exp, strap_pin_oe_n);
            chk("mdc", 0, mdc);
        end
        chk("strap_done", 1, a > 0 && a <= lsd);
        chk("strap_value", s, strap_value);
        chk("pin_func", 1, b > a && b - a <= lpf);
        chk("func_delay", FUNC_DELAY_CYC, b - a);
        chk("line_idle", m, c > 0 && c <= lid);
        if (m) chk("idle_delay", IDLE_DELAY_CYC, c - b);
        strap_in <= ~s;
        repeat (3) @(negedge clk);
        chk("strap_hold", s, strap_value);
    endtask : seq_check
    task automatic rst_check(input logic m, input logic [3:0] s);
        int k = 0;
        strap_master <= m;
        strap_in <= s;
        rst_req <= 1'b1;
        @(negedge clk);
        rst_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk("pin_func_rst", 0, pin_functional);
        // a delimiter before hand-over must be dropped
        line_ssd <= 1'b1;
        @(negedge clk);
        line_ssd <= 1'b0;
        repeat (20) @(negedge clk) k += (rx_ctrl === 1'b1);
        chk("rx_refused", 0, k);
        while (hard_reset_n !== 1'b1) @(negedge clk);
        seq_check(STRAP_RST_CYC, FUNC_RST_CYC, IDLE_RST_CYC, m, s);
    endtask : rst_check
    task automatic lat_check(input logic bp, input int lr, lt);
        int r = 0;
        int t = 0;
        fec_bypass <= bp;
        @(negedge clk);
        line_ssd <= 1'b1;
        line_rxd <= 4'h9;
        tx_ctrl <= 1'b1;
        tx_d <= 4'h6;
        @(negedge clk);
        line_ssd <= 1'b0;
        line_rxd <= 4'h6;
        tx_ctrl <= 1'b0;
        tx_d <= 4'h9;
        for (int k = 1; k < 100; k++)
        begin
            @(negedge clk);
            if (rx_ctrl === 1'b1 && r == 0) r = k;
            if (line_tx_ssd === 1'b1 && t == 0) t = k;
            if (rx_ctrl === 1'b1) chk("rx_d", 4'h9, rx_d);
            if (line_tx_ssd === 1'b1) chk("txd", 4'h6, line_txd);
        end
        chk("rx_latency", 1, r > 0 && r <= lr);
        chk("tx_latency", 1, t > 0 && t <= lt);
    endtask : lat_check
    task automatic align_check();
        chk("rx_shift_mode", 1, rx_shift_mode);
        rx_align_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk("rx_align", 0, rx_shift_mode);
        rx_align_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk("rx_shift_back", 1, rx_shift_mode);
    endtask : align_check
    // ********************************
    // main sequence and timeout
    // ********************************
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            wrap_up();
        end
    end
    initial
    begin
        {arst_n, pwr_req, rst_req, strap_master, fec_bypass} = '0;
        {rx_align_req, line_ssd, tx_ctrl} = '0;
        {strap_in, line_rxd, tx_d} = '0;
        repeat (5) @(negedge clk);
        chk("rx_shift_rst", 1, rx_shift_mode);
        chk("oe_n_rst", 1, strap_pin_oe_n);
        arst_n <= 1'b1;
        strap_master <= 1'b1;
        strap_in <= 4'ha;
        pwr_req <= 1'b1;
        seq_check(STRAP_PWR_CYC, FUNC_PWR_CYC, IDLE_PWR_CYC, 1, 4'ha);
        align_check();
        lat_check(1'b0, RX_LAT_CYC, TX_LAT_CYC);
        lat_check(1'b1, RX_LAT_BYP_CYC, TX_LAT_BYP_CYC);
        rst_check(1'b0, 4'h5);
        rst_check(1'b1, 4'h3);
        wrap_up();
    end
endmodule : pss_seq_tb
